// file: core/isc_core.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Maskable: gated by enable flag, priority settable.
// - Non-maskable: ignores enable flag and priorities.
// - Instruction-raised interrupts are always non-maskable.
// - Illegal opcode instruction always traps.
// - Overflow trap fires only with overflow flag set.
// - Arithmetic instructions update the overflow flag.
// - Break instruction always traps.
// - Trap call numbers 0-63; 0-31 share peripheral vectors.
// - Numbers 0-31 save stack flag, then clear it.
// - Return restores the saved stack flag.
// - Numbers 32-63 leave the stack flag alone.
// - Reset, watchdog, debugger, step, match are special.
// - Low reset input resets the device.
// - Watchdog raises its own non-maskable interrupt.
// - Step trace flag set: interrupt after each instruction.
// - Match enable set: trap before matching instruction.
// - Match only on an instruction's first byte.
// - Peripheral requests maskable, use vectors 0-31.
// - Low key scan input raises key request.
// - Edge pins request on the selected edge.
// - Per-source request and level; flags hold enable, level.
// - Fixed vectors are four bytes in the top region.
module isc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire isc_pkg::isc_instr_t instr,
  input wire logic fetch_valid,
  input wire logic fetch_first,
  input wire logic [19:0] fetch_addr,
  input wire logic iret,
  input wire logic core_ready,
  input wire logic watchdog_evt,
  input wire logic debugger_break,
  input wire logic [31:0] periph_req,
  input wire logic [7:0] key_scan_input_n,
  input wire logic external_edge_irq_0,
  input wire logic external_edge_irq_1,
  output logic accept_valid,
  output isc_pkg::isc_accept_t accept_info,
  output logic stack_select,
  output logic overflow_flag
);

  logic [6:0] flag_reg;
  logic [19:0] tbase_reg;
  logic [19:0] maddr_reg;
  logic men_reg;
  logic [1:0] edge_sel_reg;
  logic [31:0] req_reg;
  logic [2:0] lvl_reg [0:31];
  logic [8:0] pend_reg;
  logic int_pend_reg;
  logic [5:0] int_num_reg;
  logic [7:0] ustack_reg;
  logic [9:0] pin_s1_reg;
  logic [9:0] pin_s2_reg;
  logic [9:0] pin_s3_reg;
  logic [9:0] pin_stable_reg;
  logic [1:0] warm_reg;
  logic [5:0] last_num_reg;
  logic [3:0] last_fix_reg;
  logic last_fixed_reg;
  isc_pkg::isc_accept_t sel;
  logic sel_valid;
  logic [8:0] pend_set;
  logic [8:0] pend_clr;
  logic [31:0] src_evt;
  logic [31:0] req_clr;
  logic [2:0] best_lvl;
  logic [2:0] processor_priority_level;
  logic wr_en;
  logic rd_setup;
  logic in_ctrl;
  logic [4:0] ctrl_idx;
  logic mapped;
  logic [31:0] rd_data;
  logic edge0_evt;
  logic edge1_evt;
  logic take;

  localparam int FLG_IPL_HI = isc_pkg::FLG_IPL + 2;
  assign processor_priority_level = flag_reg[FLG_IPL_HI:isc_pkg::FLG_IPL];
  assign take = sel_valid && core_ready;
  assign rd_setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign in_ctrl = (paddr[11:7] == isc_pkg::OFS_CTRL[11:7]);
  assign ctrl_idx = paddr[6:2];

  // Pin inputs pass three flip-flops; a change counts once the last two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= isc_pkg::PIN_RST;
      pin_s2_reg <= isc_pkg::PIN_RST;
      pin_s3_reg <= isc_pkg::PIN_RST;
      pin_stable_reg <= isc_pkg::PIN_RST;
      warm_reg <= 2'h0;
    end else begin
      pin_s1_reg <= {external_edge_irq_1, external_edge_irq_0, key_scan_input_n};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (warm_reg != isc_pkg::WARM_DONE) begin
        warm_reg <= warm_reg + 2'h1;
        // During warm-up the agreed level tracks the pins, so no false edge follows reset.
        pin_stable_reg <= pin_s2_reg;
      end else begin
        for (int i = 0; i < 10; i++) begin
          if (pin_s2_reg[i] == pin_s3_reg[i]) begin
            pin_stable_reg[i] <= pin_s3_reg[i];
          end
        end
      end
    end
  end

  // Edge detection on the agreed pin level, the selected polarity only.
  always_comb begin
    edge0_evt = 1'b0;
    edge1_evt = 1'b0;
    if (warm_reg == isc_pkg::WARM_DONE && pin_s2_reg[8] == pin_s3_reg[8]) begin
      edge0_evt = (pin_s3_reg[8] != pin_stable_reg[8]) && (pin_s3_reg[8] == edge_sel_reg[0]);
    end
    if (warm_reg == isc_pkg::WARM_DONE && pin_s2_reg[9] == pin_s3_reg[9]) begin
      edge1_evt = (pin_s3_reg[9] != pin_stable_reg[9]) && (pin_s3_reg[9] == edge_sel_reg[1]);
    end
  end

  // Source events for the maskable request bits.
  always_comb begin
    src_evt = periph_req;
    src_evt[isc_pkg::SRC_KEY] = periph_req[isc_pkg::SRC_KEY] | ~&pin_stable_reg[7:0];
    src_evt[isc_pkg::SRC_EDGE0] = periph_req[isc_pkg::SRC_EDGE0] | edge0_evt;
    src_evt[isc_pkg::SRC_EDGE1] = periph_req[isc_pkg::SRC_EDGE1] | edge1_evt;
  end

  // Special and instruction events become pending bits by fixed vector slot.
  always_comb begin
    pend_set = 9'h000;
    pend_set[isc_pkg::FIX_WDT] = watchdog_evt;
    pend_set[isc_pkg::FIX_DBG] = debugger_break;
    pend_set[isc_pkg::FIX_STEP] = instr.done && flag_reg[isc_pkg::FLG_D];
    pend_set[isc_pkg::FIX_AMATCH] = fetch_valid && fetch_first && men_reg &&
      (fetch_addr == maddr_reg);
    if (instr.done) begin
      pend_set[isc_pkg::FIX_UNDEF] = (instr.kind == isc_pkg::ISC_K_UNDEF);
      pend_set[isc_pkg::FIX_BRK] = (instr.kind == isc_pkg::ISC_K_BRK);
      pend_set[isc_pkg::FIX_OVF] = (instr.kind == isc_pkg::ISC_K_INTO) &&
        flag_reg[isc_pkg::FLG_O];
    end
  end

  // Acceptance choice: special and instruction traps first, then maskable requests.
  always_comb begin
    sel_valid = 1'b0;
    sel = '0;
    best_lvl = processor_priority_level;
    sel.fixed = 1'b1;
    if (pend_reg[isc_pkg::FIX_RESET]) begin
      sel.fix_idx = isc_pkg::FIX_RESET;
    end else if (pend_reg[isc_pkg::FIX_WDT]) begin
      sel.fix_idx = isc_pkg::FIX_WDT;
    end else if (pend_reg[isc_pkg::FIX_DBG]) begin
      sel.fix_idx = isc_pkg::FIX_DBG;
    end else if (pend_reg[isc_pkg::FIX_UNDEF]) begin
      sel.fix_idx = isc_pkg::FIX_UNDEF;
    end else if (pend_reg[isc_pkg::FIX_OVF]) begin
      sel.fix_idx = isc_pkg::FIX_OVF;
    end else if (pend_reg[isc_pkg::FIX_BRK]) begin
      sel.fix_idx = isc_pkg::FIX_BRK;
    end else if (int_pend_reg) begin
      sel.fixed = 1'b0;
      sel.num = int_num_reg;
    end else if (pend_reg[isc_pkg::FIX_STEP]) begin
      sel.fix_idx = isc_pkg::FIX_STEP;
    end else if (pend_reg[isc_pkg::FIX_AMATCH]) begin
      sel.fix_idx = isc_pkg::FIX_AMATCH;
    end else begin
      sel.fixed = 1'b0;
      sel.maskable = 1'b1;
    end
    if (!sel.maskable) begin
      sel_valid = 1'b1;
    end else if (flag_reg[isc_pkg::FLG_I]) begin
      for (int i = 0; i < isc_pkg::NUM_SRC; i++) begin
        if (req_reg[i] && lvl_reg[i] > best_lvl) begin
          best_lvl = lvl_reg[i];
          sel.num = i[5:0];
          sel_valid = 1'b1;
        end
      end
    end
    if (sel.fixed) begin
      sel.vec_addr = isc_pkg::isc_vec(isc_pkg::FIXED_BASE, {2'b00, sel.fix_idx});
    end else begin
      sel.vec_addr = isc_pkg::isc_vec(tbase_reg, sel.num);
    end
  end

  always_comb begin
    pend_clr = 9'h000;
    if (take && sel.fixed) begin
      pend_clr[sel.fix_idx] = 1'b1;
    end
    req_clr = 32'h0000_0000;
    if (take && sel.maskable) begin
      req_clr[sel.num[4:0]] = 1'b1;
    end
  end

  // Pending flags: a new event wins over the clear of the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 9'h000;
      pend_reg[isc_pkg::FIX_RESET] <= 1'b1;
      int_pend_reg <= 1'b0;
      int_num_reg <= 6'h00;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      if (instr.done && instr.kind == isc_pkg::ISC_K_INT) begin
        int_pend_reg <= 1'b1;
        int_num_reg <= instr.num;
      end else if (take && !sel.fixed && !sel.maskable) begin
        int_pend_reg <= 1'b0;
      end
    end
  end

  // Flag register: software writes, overflow updates, stack flag save and restore.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= isc_pkg::FLAG_RST;
      ustack_reg <= 8'h00;
    end else begin
      if (wr_en && !in_ctrl && paddr == isc_pkg::OFS_FLAG) begin
        flag_reg <= pwdata[6:0];
      end
      if (instr.done && instr.kind == isc_pkg::ISC_K_ARITH) begin
        flag_reg[isc_pkg::FLG_O] <= instr.ovf;
      end
      if (take) begin
        ustack_reg <= {ustack_reg[6:0], flag_reg[isc_pkg::FLG_U]};
        if (!sel.fixed && !sel.num[5]) begin
          flag_reg[isc_pkg::FLG_U] <= 1'b0;
        end
      end else if (iret) begin
        flag_reg[isc_pkg::FLG_U] <= ustack_reg[0];
        ustack_reg <= {1'b0, ustack_reg[7:1]};
      end
    end
  end

  // Per-source request bits and priority levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 32'h0000_0000;
      for (int i = 0; i < isc_pkg::NUM_SRC; i++) begin
        lvl_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < isc_pkg::NUM_SRC; i++) begin
        if (src_evt[i]) begin
          req_reg[i] <= 1'b1;
        end else if (req_clr[i] || (wr_en && in_ctrl && ctrl_idx == i[4:0] &&
            !pwdata[isc_pkg::CTRL_REQ])) begin
          req_reg[i] <= 1'b0;
        end
      end
      if (wr_en && in_ctrl) begin
        lvl_reg[ctrl_idx] <= pwdata[2:0];
      end
    end
  end

  // Table base, match address and enable, edge polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbase_reg <= isc_pkg::TBASE_RST;
      maddr_reg <= isc_pkg::MADDR_RST;
      men_reg <= 1'b0;
      edge_sel_reg <= isc_pkg::EDGE_RST;
    end else if (wr_en && !in_ctrl) begin
      if (paddr == isc_pkg::OFS_TBASE) begin
        tbase_reg <= pwdata[19:0];
      end
      if (paddr == isc_pkg::OFS_MADDR) begin
        maddr_reg <= pwdata[19:0];
      end
      if (paddr == isc_pkg::OFS_MEN) begin
        men_reg <= pwdata[0];
      end
      if (paddr == isc_pkg::OFS_EDGE) begin
        edge_sel_reg <= pwdata[1:0];
      end
    end
  end

  // Accepted interrupt, presented to the core for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_valid <= 1'b0;
      accept_info <= '0;
      last_num_reg <= 6'h00;
      last_fix_reg <= 4'h0;
      last_fixed_reg <= 1'b0;
    end else begin
      accept_valid <= take;
      if (take) begin
        accept_info <= sel;
        last_num_reg <= sel.num;
        last_fix_reg <= sel.fix_idx;
        last_fixed_reg <= sel.fixed;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_select <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      stack_select <= flag_reg[isc_pkg::FLG_U];
      overflow_flag <= flag_reg[isc_pkg::FLG_O];
    end
  end

  // Register read mux.
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    if (in_ctrl) begin
      rd_data = {28'h0000000, req_reg[ctrl_idx], lvl_reg[ctrl_idx]};
    end else begin
      unique case (paddr)
        isc_pkg::OFS_FLAG: rd_data = {25'h0000000, flag_reg};
        isc_pkg::OFS_TBASE: rd_data = {12'h000, tbase_reg};
        isc_pkg::OFS_MADDR: rd_data = {12'h000, maddr_reg};
        isc_pkg::OFS_MEN: rd_data = {31'h00000000, men_reg};
        isc_pkg::OFS_EDGE: rd_data = {30'h00000000, edge_sel_reg};
        isc_pkg::OFS_STAT: rd_data = {9'h000, int_pend_reg, pend_reg, last_fixed_reg,
          last_fix_reg, 2'h0, last_num_reg};
        default: mapped = 1'b0;
      endcase
    end
  end

  // Bus answer is prepared in the setup cycle and shown in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      if (rd_setup && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/isc_pkg.sv
package isc_pkg;

  localparam int NUM_SRC = 32;
  localparam int STACK_DEPTH = 8;

  localparam logic [11:0] OFS_FLAG = 12'h000;
  localparam logic [11:0] OFS_TBASE = 12'h004;
  localparam logic [11:0] OFS_MADDR = 12'h008;
  localparam logic [11:0] OFS_MEN = 12'h00c;
  localparam logic [11:0] OFS_EDGE = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h080;

  localparam int FLG_I = 0;
  localparam int FLG_U = 1;
  localparam int FLG_D = 2;
  localparam int FLG_O = 3;
  localparam int FLG_IPL = 4;
  localparam int CTRL_REQ = 3;

  localparam logic [6:0] FLAG_RST = 7'h00;
  localparam logic [19:0] TBASE_RST = 20'h00000;
  localparam logic [19:0] MADDR_RST = 20'h00000;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [9:0] PIN_RST = 10'h0ff;
  localparam logic [1:0] WARM_DONE = 2'h3;

  localparam logic [19:0] FIXED_BASE = 20'hffffc - 20'h00020;
  localparam logic [3:0] FIX_UNDEF = 4'h0;
  localparam logic [3:0] FIX_OVF = 4'h1;
  localparam logic [3:0] FIX_BRK = 4'h2;
  localparam logic [3:0] FIX_AMATCH = 4'h3;
  localparam logic [3:0] FIX_STEP = 4'h4;
  localparam logic [3:0] FIX_WDT = 4'h5;
  localparam logic [3:0] FIX_DBG = 4'h6;
  localparam logic [3:0] FIX_RESET = 4'h8;

  localparam logic [4:0] SRC_KEY = 5'h0d;
  localparam logic [4:0] SRC_EDGE0 = 5'h1d;
  localparam logic [4:0] SRC_EDGE1 = 5'h1e;

  typedef enum logic [2:0] {
    ISC_K_NONE, ISC_K_ARITH, ISC_K_UNDEF, ISC_K_INTO, ISC_K_BRK, ISC_K_INT
  } isc_kind_t;

  typedef struct packed {
    logic done;
    isc_kind_t kind;
    logic [5:0] num;
    logic ovf;
  } isc_instr_t;

  typedef struct packed {
    logic [19:0] vec_addr;
    logic fixed;
    logic [3:0] fix_idx;
    logic [5:0] num;
    logic maskable;
  } isc_accept_t;

  function automatic logic [19:0] isc_vec(input logic [19:0] base, input logic [5:0] idx);
    isc_vec = base + {12'h000, idx, 2'b00};
  endfunction

endpackage

// file: testbench/isc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module isc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire isc_pkg::isc_instr_t instr,
  input wire logic core_ready,
  input wire logic watchdog_evt,
  input wire logic debugger_break,
  input wire logic accept_valid,
  input wire isc_pkg::isc_accept_t accept_info,
  input wire logic stack_select,
  input wire logic overflow_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no zero wait answer");
  property p_rdy1;
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_fixvec;
    accept_valid && accept_info.fixed |-> !accept_info.maskable &&
      accept_info.vec_addr == 20'hfffdc + {14'h0, accept_info.fix_idx, 2'b00};
  endproperty
  a_fixvec: assert property (p_fixvec) else $error("bad fixed vector");
  property p_ustack;
    accept_valid && !accept_info.fixed && !accept_info.num[5] |-> ##[1:2] !stack_select;
  endproperty
  a_ustack: assert property (p_ustack) else $error("stack flag kept");
  property p_undef;
    instr.done && instr.kind == isc_pkg::ISC_K_UNDEF && !watchdog_evt && !debugger_break
      ##1 core_ready |=> accept_valid && accept_info.fix_idx == isc_pkg::FIX_UNDEF;
  endproperty
  a_undef: assert property (p_undef) else $error("no undefined trap");
  property p_into;
    instr.done && instr.kind == isc_pkg::ISC_K_INTO ##1 !overflow_flag
      |=> !(accept_valid && accept_info.fix_idx == isc_pkg::FIX_OVF) [*3];
  endproperty
  a_into: assert property (p_into) else $error("overflow trap when clear");
  property p_ovf;
    instr.done && instr.kind == isc_pkg::ISC_K_ARITH |-> ##2 overflow_flag == $past(instr.ovf, 2);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag stale");
  property p_wdt;
    watchdog_evt ##1 core_ready |=> accept_valid && accept_info.fix_idx == isc_pkg::FIX_WDT;
  endproperty
  a_wdt: assert property (p_wdt) else $error("no watchdog trap");
endmodule
bind isc_core isc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .instr(instr), .core_ready(core_ready),
  .watchdog_evt(watchdog_evt), .debugger_break(debugger_break), .accept_valid(accept_valid),
  .accept_info(accept_info), .stack_select(stack_select), .overflow_flag(overflow_flag));
`default_nettype wire

// file: testbench/isc_periph.sv
`timescale 1ns/100ps
`default_nettype none
module isc_periph (
  input wire logic pclk,
  input wire logic fire,
  input wire logic [4:0] fire_num,
  input wire logic key_press,
  input wire logic [1:0] edge_lvl,
  output logic [31:0] periph_req,
  output logic [7:0] key_scan_input_n,
  output logic external_edge_irq_0,
  output logic external_edge_irq_1
);
  // One-cycle event pulse per source number; never a debugger event.
  always_ff @(posedge pclk) begin
    periph_req <= fire ? (32'h1 << fire_num) : 32'h0;
  end
  // Key pins have pull-ups, so released keys read high.
  assign key_scan_input_n = key_press ? 8'hfe : 8'hff;
  assign external_edge_irq_0 = edge_lvl[0];
  assign external_edge_irq_1 = edge_lvl[1];
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, periph_req;
  logic fetch_valid = 0, fetch_first = 0, iret = 0, watchdog_evt = 0, debugger_break = 0;
  logic fire = 0, key_press = 0, accept_valid, stack_select, overflow_flag, ext0, ext1;
  logic core_rdy = 1;
  logic [19:0] fetch_addr = 20'h00000;
  logic [4:0] fire_num = 5'h00;
  logic [1:0] edge_lvl = 2'h2;
  logic [7:0] keys_n;
  isc_pkg::isc_instr_t instr = '0;
  isc_pkg::isc_accept_t accept_info;
  int err_count = 0, compares = 0, cycles = 0;
  always #2.5 pclk = ~pclk;
  isc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr(instr), .fetch_valid(fetch_valid), .fetch_first(fetch_first),
    .fetch_addr(fetch_addr), .iret(iret), .core_ready(core_rdy), .watchdog_evt(watchdog_evt),
    .debugger_break(debugger_break), .periph_req(periph_req), .key_scan_input_n(keys_n),
    .external_edge_irq_0(ext0), .external_edge_irq_1(ext1), .accept_valid(accept_valid),
    .accept_info(accept_info), .stack_select(stack_select), .overflow_flag(overflow_flag));
  isc_periph u_per (.pclk(pclk), .fire(fire), .fire_num(fire_num), .key_press(key_press),
    .edge_lvl(edge_lvl), .periph_req(periph_req), .key_scan_input_n(keys_n),
    .external_edge_irq_0(ext0), .external_edge_irq_1(ext1));
  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop;
    end
  end
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ins(input isc_pkg::isc_kind_t k, input logic [5:0] n, input logic o);
    @(posedge pclk);
    instr <= '{1'b1, k, n, o};
    @(posedge pclk);
    instr <= '0;
  endtask
  task acc(input logic [19:0] v, input logic f);
    int i;
    i = 0;
    @(negedge pclk);
    while (accept_valid !== 1'b1 && i < 20) begin
      @(negedge pclk);
      i++;
    end
    chk(accept_valid === 1'b1 && accept_info.vec_addr === v && accept_info.fixed === f, "acc");
  endtask
  task quiet;
    repeat (8) begin
      @(negedge pclk);
      chk(accept_valid === 1'b0, "quiet");
    end
  endtask
  task src(input logic [4:0] n);
    @(posedge pclk);
    fire <= 1'b1;
    fire_num <= n;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  task fetch(input logic f);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_first <= f;
    fetch_addr <= 20'h01234;
    @(posedge pclk);
    fetch_valid <= 1'b0;
  endtask
  task pop;
    @(posedge pclk);
    iret <= 1'b1;
    @(posedge pclk);
    iret <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    acc(20'hffffc, 1'b1);
    apb(1'b1, isc_pkg::OFS_TBASE, 32'h00040000);
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000002);
    apb(1'b0, isc_pkg::OFS_FLAG, 32'h0);
    chk(r[6:0] === 7'h02 && e === 1'b0, "flag");
    apb(1'b0, 12'h100, 32'h0);
    chk(e === 1'b1 && r === 32'h0, "unmapped");
    $display("test registers done");
    ins(isc_pkg::ISC_K_UNDEF, 6'h00, 1'b0);
    acc(20'hfffdc, 1'b1);
    ins(isc_pkg::ISC_K_BRK, 6'h00, 1'b0);
    acc(20'hfffe4, 1'b1);
    ins(isc_pkg::ISC_K_ARITH, 6'h00, 1'b1);
    repeat (2) @(negedge pclk);
    chk(overflow_flag === 1'b1, "ovf");
    ins(isc_pkg::ISC_K_INTO, 6'h00, 1'b0);
    acc(20'hfffe0, 1'b1);
    ins(isc_pkg::ISC_K_ARITH, 6'h00, 1'b0);
    quiet();
    ins(isc_pkg::ISC_K_INTO, 6'h00, 1'b0);
    quiet();
    $display("test traps done");
    ins(isc_pkg::ISC_K_INT, 6'h05, 1'b0);
    acc(20'h40014, 1'b0);
    repeat (2) @(negedge pclk);
    chk(stack_select === 1'b0, "u clear");
    pop();
    chk(stack_select === 1'b1, "u back");
    ins(isc_pkg::ISC_K_INT, 6'h28, 1'b0);
    acc(20'h400a0, 1'b0);
    repeat (2) @(negedge pclk);
    chk(stack_select === 1'b1, "u kept");
    pop();
    $display("test stack done");
    @(posedge pclk);
    watchdog_evt <= 1'b1;
    @(posedge pclk);
    watchdog_evt <= 1'b0;
    acc(20'hffff0, 1'b1);
    @(posedge pclk);
    core_rdy <= 1'b0;
    debugger_break <= 1'b1;
    @(posedge pclk);
    debugger_break <= 1'b0;
    quiet();
    @(posedge pclk);
    core_rdy <= 1'b1;
    acc(20'hffff4, 1'b1);
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000006);
    ins(isc_pkg::ISC_K_ARITH, 6'h00, 1'b0);
    acc(20'hfffec, 1'b1);
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000000);
    apb(1'b1, isc_pkg::OFS_MADDR, 32'h00001234);
    apb(1'b1, isc_pkg::OFS_MEN, 32'h00000001);
    fetch(1'b0);
    quiet();
    fetch(1'b1);
    acc(20'hfffe8, 1'b1);
    apb(1'b1, isc_pkg::OFS_MEN, 32'h00000000);
    $display("test special done");
    apb(1'b1, 12'h0d8, 32'h00000003);
    src(5'd22);
    quiet();
    apb(1'b0, 12'h0d8, 32'h0);
    chk(r[3:0] === 4'hb, "req set");
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000001);
    acc(20'h40058, 1'b0);
    apb(1'b0, 12'h0d8, 32'h0);
    chk(r[3] === 1'b0, "req clear");
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000020);
    apb(1'b1, 12'h0d4, 32'h00000002);
    apb(1'b1, 12'h0dc, 32'h00000005);
    src(5'd21);
    src(5'd23);
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000021);
    acc(20'h4005c, 1'b0);
    quiet();
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000011);
    acc(20'h40054, 1'b0);
    $display("test maskable done");
    apb(1'b1, isc_pkg::OFS_FLAG, 32'h00000001);
    apb(1'b1, 12'h0b4, 32'h00000001);
    key_press <= 1'b1;
    acc(20'h40034, 1'b0);
    @(posedge pclk);
    key_press <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b1, 12'h0b4, 32'h00000001);
    repeat (10) @(posedge pclk);
    apb(1'b1, isc_pkg::OFS_EDGE, 32'h00000001);
    apb(1'b1, 12'h0f4, 32'h00000001);
    apb(1'b1, 12'h0f8, 32'h00000001);
    @(posedge pclk);
    edge_lvl <= 2'b11;
    acc(20'h40074, 1'b0);
    @(posedge pclk);
    edge_lvl <= 2'b10;
    quiet();
    @(posedge pclk);
    edge_lvl <= 2'b00;
    acc(20'h40078, 1'b0);
    apb(1'b0, isc_pkg::OFS_STAT, 32'h0);
    chk(r === 32'h0000001e && e === 1'b0, "status");
    $display("test pins done");
    report_and_stop;
  end
endmodule
`default_nettype wire
